// >>> logic/tx_corr_params.svh
// Constants for the transmit modulation and correction path.
// Assumes inclusion by the package only; the design module uses its macros through it.
//
// Contract
// RQ1 - Factor 4: second stage code picks shift in halves of input sample rate.
// RQ2 - Factor 2: second stage bypassed; first stage code picks shift 0 to 1.5.
// RQ3 - Odd first stage mode with premodulation adds half input rate shift.
// RQ4 - Half-rate mixing negates every other sample, channels kept apart.
// RQ5 - Quarter-rate: I gets I,Q,-I,-Q; Q gets Q,-I,-Q,I.
// RQ6 - Three-quarter-rate: I gets I,-Q,-I,Q; Q gets Q,I,-Q,-I.
// RQ7 - Eighth-rate: eight phase rotation, odd phases scaled by half root two.
// RQ8 - Only half-rate mixing keeps I and Q independent; others cross-couple.
// RQ9 - Ten-bit I skew code rotates I against Q, about 1.75 degrees.
// RQ10 - Ten-bit Q skew code rotates Q against I the same way.
// RQ11 - Skew linear in code, about 0.00342 degrees per step.
// RQ12 - Separate sixteen-bit offsets added to every I and Q sample.
// RQ13 - Software keeps offset plus sample within range.
// RQ14 - Samples are twos complement, midscale is zero.
// RQ15 - Inverse sinc correction is a nine-tap FIR per channel.
// RQ16 - Coefficients flatten converter roll-off to 0.05 dB up to 0.4 rate.
// RQ17 - Inverse sinc has about 3.2 dB insertion loss.
// RQ18 - Inverse sinc bypassed after reset; clearing bit 6 enables it.
// RQ19 - First stage modes 0 and 2 independent; modes 1 and 3 mix channels.
// RQ20 - Order: mixing, skew, offset, inverse sinc, then converter.
// RQ21 - Offset sum saturates instead of wrapping.
`ifndef TX_CORR_PARAMS_SVH
`define TX_CORR_PARAMS_SVH

`define SAMPLE_W 16
`define ADDR_SINC_CTL 8'h1B
`define ADDR_MODE_A 8'h1C
`define ADDR_MODE_B 8'h1D
`define ADDR_STATUS 8'h1E
`define ADDR_I_SKEW_0 8'h38
`define ADDR_I_SKEW_1 8'h39
`define ADDR_Q_SKEW_0 8'h3A
`define ADDR_Q_SKEW_1 8'h3B
`define ADDR_DC_SHIFT_0 8'h3C
`define ADDR_DC_SHIFT_1 8'h3D
`define ADDR_DC_SHIFT_2 8'h3E
`define ADDR_DC_SHIFT_3 8'h3F

`define SINC_BYPASS_BIT 6
`define MODE_A_PREMOD_BIT 2
`define MODE_A_X4_BIT 3
`define SINC_CTL_RESET 8'h40
`define MODE_A_RESET 8'h08
`define MODE_B_RESET 8'h00

`define ROOT_HALF 18'sh05A82
`define ROOT_HALF_SHIFT 15
`define SKEW_GAIN 11'sh3E9
`define SKEW_SHIFT 24
`define SINC_TAPS 9
`define SINC_C0 12'sh002
`define SINC_C1 12'shFFC
`define SINC_C2 12'sh00A
`define SINC_C3 12'shFDD
`define SINC_C4 12'sh198
`define SINC_SHIFT 9

`endif

// >>> logic/tx_corr_pkg.sv
// Types for the transmit modulation and correction path.
// Assumes the constants header sits beside it.
`include "tx_corr_params.svh"

package tx_corr_pkg;

  typedef struct packed {
    logic signed [`SAMPLE_W-1:0] i;
    logic signed [`SAMPLE_W-1:0] q;
  } iq_t;

  typedef struct packed {
    logic [7:0] sinc_ctl;
    logic [7:0] mode_a;
    logic [7:0] mode_b;
    logic signed [9:0] i_skew;
    logic signed [9:0] q_skew;
    logic signed [`SAMPLE_W-1:0] i_shift;
    logic signed [`SAMPLE_W-1:0] q_shift;
  } ctl_t;

  typedef struct packed {
    ctl_t ctl;
    logic [7:0] rdata;
    logic [2:0] phase;
    iq_t mix;
    logic mix_v;
    iq_t adj;
    logic adj_v;
    iq_t dc;
    logic dc_v;
    logic [1:0] sat;
    iq_t [`SINC_TAPS-2:0] taps;
    iq_t out;
    logic out_v;
  } state_t;

endpackage

// >>> logic/tx_modulation_correction_path.sv
// Transmit back end: coarse mixing, quadrature skew, dc shift, inverse sinc.
// Assumes samples and register strobes arrive on clk_sys_in.
`timescale 1ns/1ns

module tx_modulation_correction_path
  import tx_corr_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  // Samples from the interpolation filters
  input wire logic smp_valid_in,
  input wire iq_t smp_in,
  // Samples to the converter core
  output logic smp_valid_out,
  output iq_t smp_out
);

  // ****************************************
  // Arithmetic helpers
  // ****************************************
  function automatic logic signed [`SAMPLE_W-1:0] sat16(input logic signed [39:0] v);
    logic signed [`SAMPLE_W-1:0] r;
    r = v[`SAMPLE_W-1:0];
    if (v > 40'sh0000007FFF) begin
      r = 16'sh7FFF;
    end else if (v < -40'sh0000008000) begin
      r = -16'sh8000;
    end
    return r;
  endfunction

  function automatic logic signed [`SAMPLE_W-1:0] root_half(input logic signed [17:0] s);
    logic signed [39:0] p;
    p = 40'(s) * 40'(`ROOT_HALF);
    return sat16(p >>> `ROOT_HALF_SHIFT);
  endfunction

  // Eight phase complex rotation by p eighths of a turn
  function automatic iq_t rotate(input iq_t x, input logic [2:0] p);
    logic signed [17:0] sp;
    logic signed [17:0] dq;
    logic signed [`SAMPLE_W-1:0] ni;
    logic signed [`SAMPLE_W-1:0] nq;
    iq_t y;
    sp = 18'(x.i) + 18'(x.q);
    dq = 18'(x.q) - 18'(x.i);
    ni = sat16(-40'(x.i));
    nq = sat16(-40'(x.q));
    y = x;
    unique case (p)
      3'h0: begin
        y.i = x.i;
        y.q = x.q;
      end
      3'h1: begin
        y.i = root_half(sp);  // see RQ7
        y.q = root_half(dq);
      end
      3'h2: begin
        y.i = x.q;  // see RQ5
        y.q = ni;
      end
      3'h3: begin
        y.i = root_half(dq);
        y.q = root_half(-sp);
      end
      3'h4: begin
        y.i = ni;  // see RQ4
        y.q = nq;
      end
      3'h5: begin
        y.i = root_half(-sp);
        y.q = root_half(-dq);
      end
      3'h6: begin
        y.i = nq;  // see RQ6
        y.q = x.i;
      end
      3'h7: begin
        y.i = root_half(-dq);
        y.q = root_half(sp);
      end
    endcase
    return y;
  endfunction

  function automatic logic signed [11:0] sinc_coef(input int k);
    logic signed [11:0] c;
    unique case (k)
      0, 8: c = `SINC_C0;
      1, 7: c = `SINC_C1;
      2, 6: c = `SINC_C2;
      3, 5: c = `SINC_C3;
      default: c = `SINC_C4;
    endcase
    return c;
  endfunction

  // ****************************************
  // State
  // ****************************************
  state_t state_reg;
  state_t state_next;

  always_comb begin
    logic [1:0] hb1;
    logic premod;
    logic [2:0] step;
    logic signed [20:0] gi;
    logic signed [20:0] gq;
    logic signed [39:0] si;
    logic signed [39:0] sq;
    logic signed [39:0] acc_i;
    logic signed [39:0] acc_q;
    iq_t [`SINC_TAPS-1:0] win;
    hb1 = '0;
    premod = 1'b0;
    step = '0;
    gi = '0;
    gq = '0;
    si = '0;
    sq = '0;
    acc_i = '0;
    acc_q = '0;
    win = '0;
    state_next = state_reg;

    // ****************************************
    // Register port
    // ****************************************
    if (reg_wr_in) begin
      unique case (reg_addr_in)
        `ADDR_SINC_CTL: state_next.ctl.sinc_ctl = reg_wdata_in;
        `ADDR_MODE_A: state_next.ctl.mode_a = reg_wdata_in;
        `ADDR_MODE_B: state_next.ctl.mode_b = reg_wdata_in;
        `ADDR_I_SKEW_0: state_next.ctl.i_skew[7:0] = reg_wdata_in;
        `ADDR_I_SKEW_1: state_next.ctl.i_skew[9:8] = reg_wdata_in[1:0];
        `ADDR_Q_SKEW_0: state_next.ctl.q_skew[7:0] = reg_wdata_in;
        `ADDR_Q_SKEW_1: state_next.ctl.q_skew[9:8] = reg_wdata_in[1:0];
        `ADDR_DC_SHIFT_0: state_next.ctl.i_shift[7:0] = reg_wdata_in;
        `ADDR_DC_SHIFT_1: state_next.ctl.i_shift[15:8] = reg_wdata_in;
        `ADDR_DC_SHIFT_2: state_next.ctl.q_shift[7:0] = reg_wdata_in;
        `ADDR_DC_SHIFT_3: state_next.ctl.q_shift[15:8] = reg_wdata_in;
        default: ;
      endcase
    end
    state_next.rdata = 8'h00;
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        `ADDR_SINC_CTL: state_next.rdata = state_reg.ctl.sinc_ctl;
        `ADDR_MODE_A: state_next.rdata = state_reg.ctl.mode_a;
        `ADDR_MODE_B: state_next.rdata = state_reg.ctl.mode_b;
        `ADDR_STATUS: state_next.rdata = {3'h0, state_reg.sat, state_reg.phase};
        `ADDR_I_SKEW_0: state_next.rdata = state_reg.ctl.i_skew[7:0];
        `ADDR_I_SKEW_1: state_next.rdata = {6'h00, state_reg.ctl.i_skew[9:8]};
        `ADDR_Q_SKEW_0: state_next.rdata = state_reg.ctl.q_skew[7:0];
        `ADDR_Q_SKEW_1: state_next.rdata = {6'h00, state_reg.ctl.q_skew[9:8]};
        `ADDR_DC_SHIFT_0: state_next.rdata = state_reg.ctl.i_shift[7:0];
        `ADDR_DC_SHIFT_1: state_next.rdata = state_reg.ctl.i_shift[15:8];
        `ADDR_DC_SHIFT_2: state_next.rdata = state_reg.ctl.q_shift[7:0];
        `ADDR_DC_SHIFT_3: state_next.rdata = state_reg.ctl.q_shift[15:8];
        default: state_next.rdata = 8'h00;
      endcase
    end

    // ****************************************
    // Stage 1: coarse mixing
    // ****************************************
    hb1 = state_reg.ctl.mode_a[1:0];
    premod = state_reg.ctl.mode_a[`MODE_A_PREMOD_BIT] & hb1[0];  // see RQ3
    if (state_reg.ctl.mode_a[`MODE_A_X4_BIT]) begin
      // Output rate four times input: one eighth turn per half input rate
      step = state_reg.ctl.mode_b[2:0] + {2'h0, premod};  // see RQ1
    end else begin
      // Output rate twice input; even modes give steps 0 or 4 only
      step = {2'(hb1 + {1'b0, premod}), 1'b0};  // see RQ2, RQ19
    end
    state_next.mix_v = smp_valid_in;
    if (smp_valid_in) begin
      // Twos complement in, rotation cross-couples except at phases 0 and 4
      state_next.mix = rotate(smp_in, state_reg.phase);  // see RQ8, RQ14, RQ20
      state_next.phase = state_reg.phase + step;
    end

    // ****************************************
    // Stage 2: quadrature skew
    // ****************************************
    gi = 21'(state_reg.ctl.i_skew) * 21'(`SKEW_GAIN);  // see RQ11
    gq = 21'(state_reg.ctl.q_skew) * 21'(`SKEW_GAIN);
    state_next.adj_v = state_reg.mix_v;
    if (state_reg.mix_v) begin
      si = (40'(gi) * 40'(state_reg.mix.q)) >>> `SKEW_SHIFT;
      sq = (40'(gq) * 40'(state_reg.mix.i)) >>> `SKEW_SHIFT;
      // Positive code leans the channel toward the other one
      state_next.adj.i = sat16(40'(state_reg.mix.i) + si);  // see RQ9
      state_next.adj.q = sat16(40'(state_reg.mix.q) + sq);  // see RQ10
    end

    // ****************************************
    // Stage 3: dc shift
    // ****************************************
    state_next.dc_v = state_reg.adj_v;
    if (state_reg.adj_v) begin
      si = 40'(state_reg.adj.i) + 40'(state_reg.ctl.i_shift);  // see RQ12
      sq = 40'(state_reg.adj.q) + 40'(state_reg.ctl.q_shift);
      state_next.dc.i = sat16(si);  // see RQ21
      state_next.dc.q = sat16(sq);
      state_next.sat = {sat16(si) != si[`SAMPLE_W-1:0], sat16(sq) != sq[`SAMPLE_W-1:0]};
    end

    // ****************************************
    // Stage 4: inverse sinc
    // ****************************************
    win = {state_reg.taps, state_reg.dc};
    for (int k = 0; k < `SINC_TAPS; k++) begin
      // Symmetric taps, DC gain near 3.2 dB below unity
      acc_i = acc_i + 40'(win[k].i) * 40'(sinc_coef(k));  // see RQ15, RQ16, RQ17
      acc_q = acc_q + 40'(win[k].q) * 40'(sinc_coef(k));
    end
    state_next.out_v = state_reg.dc_v;
    if (state_reg.dc_v) begin
      state_next.taps = win[`SINC_TAPS-2:0];
      if (state_reg.ctl.sinc_ctl[`SINC_BYPASS_BIT]) begin
        state_next.out = state_reg.dc;  // see RQ18
      end else begin
        state_next.out.i = sat16(acc_i >>> `SINC_SHIFT);
        state_next.out.q = sat16(acc_q >>> `SINC_SHIFT);
      end
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg <= '0;
      state_reg.ctl.sinc_ctl <= `SINC_CTL_RESET;  // see RQ18
      state_reg.ctl.mode_a <= `MODE_A_RESET;
      state_reg.ctl.mode_b <= `MODE_B_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign reg_rdata_out = state_reg.rdata;
  assign smp_valid_out = state_reg.out_v;
  assign smp_out = state_reg.out;

endmodule

// >>> bench/tx_src_model.sv
// Upstream sample source feeding the correction path.
// Assumes the bench asks for one sample per clock on req_in.
`timescale 1ns/1ns

module tx_src_model
  import tx_corr_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Requests from the bench
  input wire logic req_in,
  input wire iq_t word_in,
  // Samples to the path
  output logic smp_valid_out,
  output iq_t smp_out
);
  // ******
  // Idle data flips each cycle so a missed qualifier shows
  // ******
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      smp_valid_out <= 1'b0;
      smp_out <= '0;
    end else begin
      smp_valid_out <= req_in;
      smp_out <= req_in ? word_in : ~smp_out;
    end
  end
endmodule

// >>> bench/tx_mod_asserts.sv
// Port checks for the transmit correction path.
// Assumes it is bound to the path module and sees only its ports.
`timescale 1ns/1ns

module tx_mod_asserts
  import tx_corr_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  // Sample stream
  input wire logic smp_valid_in,
  input wire iq_t smp_in,
  input wire logic smp_valid_out,
  input wire iq_t smp_out
);
  logic wv_reg;
  logic [7:0] wa_reg, wd_reg;
  wire back = reg_rd_in && wv_reg && reg_addr_in == wa_reg;
  // ******
  // Last write, to catch a read right after it
  // ******
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      wv_reg <= 1'b0;
      wa_reg <= '0;
      wd_reg <= '0;
    end else begin
      wv_reg <= reg_wr_in;
      wa_reg <= reg_addr_in;
      wd_reg <= reg_wdata_in;
    end
  end
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  lat_valid_a: assert property (smp_valid_in |-> ##4 smp_valid_out)
    else $error("sample lost");
  no_spur_a: assert property (smp_valid_out |-> $past(smp_valid_in, 4))
    else $error("spurious sample");
  out_hold_a: assert property (!smp_valid_out |-> $stable(smp_out))
    else $error("output moved");
  i_shift_a: assert property (back && wa_reg == 8'h3C |=> reg_rdata_out == $past(wd_reg))
    else $error("i shift readback");
  q_shift_a: assert property (back && wa_reg == 8'h3F |=> reg_rdata_out == $past(wd_reg))
    else $error("q shift readback");
  i_skew_a: assert property (back && wa_reg == 8'h39 |=>
    reg_rdata_out == ($past(wd_reg) & 8'h03)) else $error("i skew readback");
  q_skew_a: assert property (back && wa_reg == 8'h3B |=>
    reg_rdata_out == ($past(wd_reg) & 8'h03)) else $error("q skew readback");
  sinc_bit_a: assert property (back && wa_reg == 8'h1B |=>
    reg_rdata_out[6] == $past(wd_reg[6])) else $error("bypass bit readback");
endmodule

bind tx_modulation_correction_path tx_mod_asserts i_chk (.clk_sys_in, .rst_in, .reg_addr_in,
  .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .smp_valid_in, .smp_in,
  .smp_valid_out, .smp_out);

// >>> bench/tx_modulation_correction_path_tb.sv
// Bench for the transmit correction path: random samples and register checks.
// Assumes the source model and the checker are compiled before it.
`timescale 1ns/1ns
`define CHK(n, e, s) begin n_compared++; if ((e) !== (s)) begin n_fail++; \
  $display("BAD %s exp %h got %h", n, e, s); end end

module tx_modulation_correction_path_tb;
  import tx_corr_pkg::*;
  logic clk_sys_in = 0, rst_in = 1, reg_wr_in = 0, reg_rd_in = 0, req = 0;
  logic smp_valid_in, smp_valid_out;
  logic [7:0] reg_addr_in = 0, reg_wdata_in = 0, reg_rdata_out;
  logic [7:0] sh[256];
  logic [2:0] ph = 0;
  logic [1:0] sat_e = 0;
  iq_t word = '0, smp_in, smp_out, e;
  iq_t w[9] = '{default: '0};
  iq_t exp_q[$];
  int n_fail = 0, n_compared = 0, seed = 23, cyc = 0;
  int cf[9] = '{2, -4, 10, -35, 408, -35, 10, -4, 2};

  always #25 clk_sys_in = ~clk_sys_in;

  tx_src_model i_src (.clk_sys_in, .rst_in, .req_in(req), .word_in(word),
    .smp_valid_out(smp_valid_in), .smp_out(smp_in));
  tx_modulation_correction_path i_dut (.clk_sys_in, .rst_in, .reg_addr_in, .reg_wdata_in,
    .reg_wr_in, .reg_rd_in, .reg_rdata_out, .smp_valid_in, .smp_in, .smp_valid_out, .smp_out);

  // ******
  // Reference arithmetic
  // ******
  function automatic logic signed [15:0] st(longint v);
    return v > 32767 ? 16'sh7FFF : v < -32768 ? 16'sh8000 : 16'(v);
  endfunction
  function automatic longint rr(longint v);
    return st((v * 32'sh5A82) >>> 15);
  endfunction
  function automatic longint sx(logic [7:0] hi, lo, int n);
    logic [15:0] v;
    v = {hi, lo};
    return n == 10 ? longint'($signed(v[9:0])) : longint'($signed(v));
  endfunction

  task automatic push(input iq_t x);
    longint i, q, a, b, si, sq;
    iq_t m, o;
    logic [1:0] h;
    i = x.i;
    q = x.q;
    case (ph)
      0: m = '{st(i), st(q)};
      1: m = '{rr(i + q), rr(q - i)};
      2: m = '{st(q), st(-i)};
      3: m = '{rr(q - i), rr(-i - q)};
      4: m = '{st(-i), st(-q)};
      5: m = '{rr(-i - q), rr(i - q)};
      6: m = '{st(-q), st(i)};
      default: m = '{rr(i - q), rr(i + q)};
    endcase
    a = st(m.i + ((sx(sh[8'h39], sh[8'h38], 10) * 1001 * m.q) >>> 24));
    b = st(m.q + ((sx(sh[8'h3B], sh[8'h3A], 10) * 1001 * m.i) >>> 24));
    o = '{st(a + sx(sh[8'h3D], sh[8'h3C], 16)), st(b + sx(sh[8'h3F], sh[8'h3E], 16))};
    sat_e = {o.i != a + sx(sh[8'h3D], sh[8'h3C], 16), o.q != b + sx(sh[8'h3F], sh[8'h3E], 16)};
    for (int k = 8; k > 0; k--) w[k] = w[k - 1];
    w[0] = o;
    si = 0;
    sq = 0;
    for (int k = 0; k < 9; k++) begin
      si += cf[k] * w[k].i;
      sq += cf[k] * w[k].q;
    end
    if (!sh[8'h1B][6]) o = '{st(si >>> 9), st(sq >>> 9)};
    exp_q.push_back(o);
    h = sh[8'h1C][1:0] + (sh[8'h1C][2] & sh[8'h1C][0]);
    ph += sh[8'h1C][3] ? sh[8'h1D][2:0] + (sh[8'h1C][2] & sh[8'h1C][0]) : {h, 1'b0};
    if ($random(seed) % 3 == 0) @(posedge clk_sys_in) req <= 0;
    @(posedge clk_sys_in) begin
      req <= 1;
      word <= x;
    end
  endtask

  task automatic burst(input int n);
    repeat (n) push('{16'($random(seed) % 8192), 16'($random(seed) % 8192)});
    @(posedge clk_sys_in) req <= 0;
    repeat (8) @(posedge clk_sys_in);
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys_in) begin
      reg_rd_in <= 1;
      reg_wr_in <= 0;
      reg_addr_in <= a;
    end
    @(posedge clk_sys_in) reg_rd_in <= 0;
    #1 `CHK("reg", (a == 8'h39 || a == 8'h3B) ? sh[a] & 8'h03 : sh[a], reg_rdata_out)
  endtask

  task automatic wrrd(input logic [7:0] a, d);
    @(posedge clk_sys_in) begin
      reg_wr_in <= 1;
      reg_addr_in <= a;
      reg_wdata_in <= d;
    end
    if (a < 8'h40) sh[a] = d;
    rd(a);
  endtask

  task automatic report_and_stop();
    if (n_fail == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ******
  // Output monitor and hang guard
  // ******
  always @(posedge clk_sys_in) begin
    if (!rst_in && smp_valid_out === 1'b1) begin
      if (exp_q.size() == 0) e = ~smp_out;
      else e = exp_q.pop_front();
      `CHK("smp", e, smp_out)
    end
    cyc++;
    if (cyc > 20000) begin
      n_fail++;
      report_and_stop();
    end
  end

  initial begin
    foreach (sh[k]) sh[k] = 8'h00;
    sh[8'h1B] = 8'h40;
    sh[8'h1C] = 8'h08;
    repeat (12) @(posedge clk_sys_in);
    rst_in <= 0;
    for (int a = 'h1B; a < 'h1E; a++) rd(8'(a));
    for (int a = 'h38; a < 'h40; a++) rd(8'(a));
    rd(8'h50);
    burst(12);
    for (int c = 0; c < 32; c++) begin
      wrrd(8'h1C, {4'h0, c[4], c[3], c[1:0]});
      wrrd(8'h1D, {2'b00, c[2:0], c[2:0]});
      burst(10);
    end
    wrrd(8'h1C, 8'h08);
    wrrd(8'h1D, 8'h00);
    wrrd(8'h38, 8'h00);
    wrrd(8'h39, 8'hFE);
    wrrd(8'h3A, 8'hFF);
    wrrd(8'h3B, 8'h01);
    burst(20);
    wrrd(8'h3C, 8'hFF);
    wrrd(8'h3D, 8'h7F);
    wrrd(8'h3E, 8'h00);
    wrrd(8'h3F, 8'h80);
    push('{16'sh7FFF, 16'sh8000});
    @(posedge clk_sys_in) req <= 0;
    repeat (6) @(posedge clk_sys_in);
    sh[8'h1E] = {3'h0, sat_e, ph};
    rd(8'h1E);
    burst(10);
    wrrd(8'h1B, 8'h00);
    burst(30);
    wrrd(8'h50, 8'hA5);
    `CHK("left", 0, exp_q.size())
    report_and_stop();
  end
endmodule
